// >>> hw/cnmp_parser.sv
// Caller number message parser, single_message_layout frames
// Functional notes
// - Frame opens with two header bytes; the first is message type.
// - Type 04 is number, 06 message waiting, 08 reserved/unknown.
// - Second header byte counts following data bytes; marks data end.
// - First four data bytes are month and day digits.
// - Next four data bytes are hour and minute digits.
// - Last ten data bytes are the calling number digits.
// - Parsing starts on bytes alone; no ring needed.
// - Sum of bytes from type on plus checksum must be zero mod 256.
// - Bad checksum publishes nothing, but its digits stay captured and come out with the next good non-number frame; no retransmit request.
`timescale 1ns/1ps
`include "cnmp_defs.svh"
module cnmp_parser (
   input wire logic I_CLOCK,                   // 250 MHz clock
   input wire logic I_RST_N,                   // Sync reset, active low
   input wire logic I_BYTE_VALID,              // Received byte valid
   input wire logic [7:0] I_BYTE,              // Received byte
   output logic O_BYTE_READY,                  // Buffer room, registered, one cycle late
   input wire logic I_HOLD,                    // Downstream stall
   output logic O_FRAME_VALID,                 // Good frame, one cycle
   output logic O_FRAME_ERROR,                 // Dropped frame, one cycle
   output cnmp_pkg::cnmp_kind_t O_KIND,        // Decoded message type
   output logic [7:0] O_TYPE,                  // Raw message type
   output logic [31:0] O_DATE,                 // Month, day ASCII
   output logic [31:0] O_TIME,                 // Hour, minute ASCII
   output logic [79:0] O_NUMBER                // Ten ASCII digits
);
   import cnmp_pkg::*;

   // ----------------------------------------
   // Input buffer
   // ----------------------------------------
   cnmp_byte_if bif ();
   logic buf_room;
   cnmp_skid_buf #(.WIDTH(8)) u_buf (
      .i_clk(I_CLOCK),
      .i_rst_n(I_RST_N),
      .i_valid(I_BYTE_VALID),
      .i_data(I_BYTE),
      .o_ready(buf_room),
      .out(bif)
   );
   assign bif.ready = !I_HOLD;
   wire take = bif.valid && bif.ready;
   wire [7:0] b = bif.data;

   // ----------------------------------------
   // Parser state
   // ----------------------------------------
   cnmp_state_t st_r, st_nxt;
   logic [7:0] sum_r, len_r, idx_r, type_r;
   logic [31:0] date_r, time_r;
   logic [79:0] num_r;

   function automatic cnmp_kind_t kind_of(input logic [7:0] t);
      if (t == `CNMP_TYPE_NUMBER)
         return CNMP_KIND_NUMBER;
      else if (t == `CNMP_TYPE_WAITING)
         return CNMP_KIND_WAITING;
      else if (t == `CNMP_TYPE_RESERVED)
         return CNMP_KIND_UNKNOWN; // Reserved, never a known type
      else
         return CNMP_KIND_UNKNOWN;
   endfunction : kind_of

   wire [7:0] sum_add = sum_r + b;
   wire is_num = (type_r == `CNMP_TYPE_NUMBER);
   wire in_date = idx_r < `CNMP_DATE_LEN;
   wire in_time = !in_date && (idx_r < `CNMP_TIME_END);
   wire [7:0] num_from = (len_r > `CNMP_NUM_LEN) ?
      len_r - `CNMP_NUM_LEN : `CNMP_NUM_START;
   wire in_num = idx_r >= num_from;
   wire last_data = (idx_r + 8'h01) == len_r;
   wire sum_ok = sum_add == 8'h00;

   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         CNMP_ST_TYPE: if (take) st_nxt = CNMP_ST_LEN;
         CNMP_ST_LEN:
            if (take)
               st_nxt = (b == 8'h00) ? CNMP_ST_SUM : CNMP_ST_DATA;
         CNMP_ST_DATA: if (take && last_data) st_nxt = CNMP_ST_SUM;
         CNMP_ST_SUM: if (take) st_nxt = CNMP_ST_TYPE;
         default: st_nxt = CNMP_ST_TYPE;
      endcase
   end

   // ----------------------------------------
   // Capture strobes
   // ----------------------------------------
   wire take_type = take && (st_r == CNMP_ST_TYPE);
   wire take_len = take && (st_r == CNMP_ST_LEN);
   wire take_data = take && (st_r == CNMP_ST_DATA);
   wire take_sum = take && (st_r == CNMP_ST_SUM);
   wire cap_date = take_data && is_num && in_date;
   wire cap_time = take_data && is_num && in_time;
   wire cap_num = take_data && is_num && in_num;
   wire good_end = take_sum && sum_ok;
   wire bad_end = take_sum && !sum_ok;

   // ----------------------------------------
   // Frame state and running sum
   // ----------------------------------------
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_N)
         st_r <= CNMP_ST_TYPE;
      else
         st_r <= st_nxt;
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_N)
         sum_r <= 8'h00;
      else if (take_sum)
         sum_r <= 8'h00;
      else if (take)
         sum_r <= sum_add;
   end

   // ----------------------------------------
   // Header capture
   // ----------------------------------------
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_N)
         type_r <= 8'h00;
      else if (take_type)
         type_r <= b;
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_N)
         len_r <= 8'h00;
      else if (take_len)
         len_r <= b;
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_N)
         idx_r <= 8'h00;
      else if (take_len)
         idx_r <= 8'h00;
      else if (take_data)
         idx_r <= idx_r + 8'h01;
   end

   // ----------------------------------------
   // Field capture, number frames only
   // ----------------------------------------
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_N)
         date_r <= 32'h0;
      else if (cap_date)
         date_r <= {date_r[23:0], b};
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_N)
         time_r <= 32'h0;
      else if (cap_time)
         time_r <= {time_r[23:0], b};
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_N)
         num_r <= 80'h0;
      else if (cap_num)
         num_r <= {num_r[71:0], b};
   end

   // ----------------------------------------
   // Published results
   // ----------------------------------------
   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_N)
      begin
         O_BYTE_READY <= 1'b0;
         O_FRAME_VALID <= 1'b0;
         O_FRAME_ERROR <= 1'b0;
      end
      else
      begin
         O_BYTE_READY <= buf_room;
         O_FRAME_VALID <= good_end;
         O_FRAME_ERROR <= bad_end;
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (!I_RST_N)
      begin
         O_KIND <= CNMP_KIND_NONE;
         O_TYPE <= 8'h00;
         O_DATE <= 32'h0;
         O_TIME <= 32'h0;
         O_NUMBER <= 80'h0;
      end
      else if (good_end)
      begin
         O_KIND <= kind_of(type_r);
         O_TYPE <= type_r;
         O_DATE <= date_r;
         O_TIME <= time_r;
         O_NUMBER <= num_r;
      end
   end
endmodule : cnmp_parser

// >>> hw/cnmp_defs.svh
// Constants for the caller number message parser
`ifndef CNMP_DEFS_SVH
`define CNMP_DEFS_SVH
`define CNMP_TYPE_NUMBER 8'h04
`define CNMP_TYPE_WAITING 8'h06
`define CNMP_TYPE_RESERVED 8'h08
`define CNMP_DATE_LEN 8'h04
`define CNMP_TIME_END 8'h08
`define CNMP_NUM_LEN 8'h0A
`define CNMP_NUM_START 8'h08
`endif

// >>> hw/cnmp_pkg.sv
// Types for the caller number message parser
package cnmp_pkg;
   typedef enum logic [1:0] {
      CNMP_KIND_NONE,
      CNMP_KIND_NUMBER,
      CNMP_KIND_WAITING,
      CNMP_KIND_UNKNOWN
   } cnmp_kind_t;
   typedef enum {
      CNMP_ST_TYPE,
      CNMP_ST_LEN,
      CNMP_ST_DATA,
      CNMP_ST_SUM
   } cnmp_state_t;
endpackage : cnmp_pkg

// >>> hw/cnmp_byte_if.sv
// Byte stream carrier between the buffer and the parser
`timescale 1ns/1ps
interface cnmp_byte_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface : cnmp_byte_if

// >>> hw/cnmp_skid_buf.sv
// Two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ps
module cnmp_skid_buf #(
   parameter int WIDTH = 8
) (
   input wire logic i_clk,             // Clock
   input wire logic i_rst_n,           // Sync reset, active low
   input wire logic i_valid,           // Upstream word valid
   input wire logic [WIDTH-1:0] i_data, // Upstream word
   output logic o_ready,               // Room for a word
   cnmp_byte_if.src out                // Downstream side
);
   logic [WIDTH-1:0] mem_r [2];
   logic wp_r;
   logic rp_r;
   logic [1:0] cnt_r;
   wire push = i_valid && o_ready;
   wire pop = out.valid && out.ready;

   assign o_ready = (cnt_r != 2'h2);
   assign out.valid = (cnt_r != 2'h0);
   assign out.data = mem_r[rp_r];

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            mem_r[wp_r] <= i_data;
            wp_r <= ~wp_r;
         end
         if (pop)
            rp_r <= ~rp_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : cnmp_skid_buf

// >>> dv/cnmp_src_model.sv
// Upstream byte receiver model feeding the parser
`timescale 1ns/1ps
module cnmp_src_model (
   input wire logic i_clk,    // Clock
   input wire logic i_ready,  // Buffer room, lagged
   output logic o_valid,      // Byte offered
   output logic [7:0] o_data  // Byte
);
   initial
   begin
      o_valid = 1'b0;
      o_data = 8'h00;
   end
   // Offer one byte, then leave a gap for the lagged room flag
   task automatic send(input logic [7:0] b);
      int n;
      for (n = 0; n < 50 && i_ready !== 1'b1; n++)
         @(negedge i_clk);
      if (n == 50)
      begin
         tb.error_cnt++;
         tb.give_verdict();
      end
      else
      begin
         o_valid = 1'b1;
         o_data = b;
         @(negedge i_clk);
         o_valid = 1'b0;
         o_data = ~b;
         repeat (2) @(negedge i_clk);
      end
   endtask : send
   // Quiet link for the ring and the silent gap before a frame
   task automatic ring_gap(input int cycles);
      o_valid = 1'b0;
      repeat (cycles) @(negedge i_clk);
   endtask : ring_gap
endmodule : cnmp_src_model

// >>> dv/cnmp_parser_checker.sv
// Assertions on the parser's top ports
`timescale 1ns/1ps
module cnmp_parser_checker (
   input wire logic I_CLOCK,               // Clock
   input wire logic I_RST_N,               // Reset
   input wire logic O_FRAME_VALID,         // Good frame
   input wire logic O_FRAME_ERROR,         // Dropped frame
   input cnmp_pkg::cnmp_kind_t O_KIND,     // Kind
   input wire logic [7:0] O_TYPE,          // Raw type
   input wire logic [31:0] O_DATE,         // Date
   input wire logic [79:0] O_NUMBER        // Number
);
   import cnmp_pkg::*;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_N);
   sequence s_one_pulse;
      O_FRAME_VALID ##1 !O_FRAME_VALID;
   endsequence
   a_valid_one_cycle: assert property ($rose(O_FRAME_VALID) |-> s_one_pulse)
      else $error("valid too long");
   a_error_one_cycle: assert property (O_FRAME_ERROR |=> !O_FRAME_ERROR)
      else $error("error too long");
   a_pulse_excl: assert property (!(O_FRAME_VALID && O_FRAME_ERROR))
      else $error("both pulses");
   a_fields_hold: assert property (!O_FRAME_VALID |-> $stable(O_DATE)
      && $stable(O_NUMBER)) else $error("fields moved");
   a_error_keeps: assert property (O_FRAME_ERROR |-> $stable(O_TYPE))
      else $error("bad frame published");
   a_kind_number: assert property (O_FRAME_VALID && O_TYPE == 8'h04
      |-> O_KIND == CNMP_KIND_NUMBER) else $error("kind not number");
   a_kind_waiting: assert property (O_FRAME_VALID && O_TYPE == 8'h06
      |-> O_KIND == CNMP_KIND_WAITING) else $error("kind not waiting");
   a_kind_other: assert property (O_FRAME_VALID && O_TYPE != 8'h04
      && O_TYPE != 8'h06 |-> O_KIND == CNMP_KIND_UNKNOWN)
      else $error("kind not unknown");
endmodule : cnmp_parser_checker
bind cnmp_parser cnmp_parser_checker u_chk (.I_CLOCK, .I_RST_N,
   .O_FRAME_VALID, .O_FRAME_ERROR, .O_KIND, .O_TYPE, .O_DATE, .O_NUMBER);

// >>> dv/tb.sv
// Testbench for the caller number message parser
`timescale 1ns/1ps
`define CHK(a, b) cmp_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("BAD %0t %h %h", $time, (a), (b)); end
module tb;
   import cnmp_pkg::*;
   logic I_CLOCK = 1'b0;
   logic I_RST_N = 1'b0;
   logic I_HOLD = 1'b0;
   logic I_BYTE_VALID, O_BYTE_READY, O_FRAME_VALID, O_FRAME_ERROR, last_ok;
   logic [7:0] I_BYTE, O_TYPE;
   logic [31:0] O_DATE, O_TIME;
   logic [79:0] O_NUMBER, num_exp;
   cnmp_kind_t O_KIND;
   int error_cnt = 0, cmp_count = 0, seen = 0, pulses = 0;
   always #2 I_CLOCK = ~I_CLOCK;
   cnmp_parser dut (.I_CLOCK, .I_RST_N, .I_BYTE_VALID, .I_BYTE,
      .O_BYTE_READY, .I_HOLD, .O_FRAME_VALID, .O_FRAME_ERROR, .O_KIND,
      .O_TYPE, .O_DATE, .O_TIME, .O_NUMBER);
   cnmp_src_model src (.i_clk(I_CLOCK), .i_ready(O_BYTE_READY),
      .o_valid(I_BYTE_VALID), .o_data(I_BYTE));
   always @(posedge I_CLOCK)
      if (O_FRAME_VALID === 1'b1 || O_FRAME_ERROR === 1'b1)
      begin
         pulses++;
         last_ok = O_FRAME_VALID;
      end
   task automatic give_verdict();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // Whole frame with computed checksum, then wait for its verdict
   task automatic send_frame(input logic [7:0] ty, input logic [143:0] pl,
      input int len, input logic [7:0] flip);
      logic [7:0] s;
      int k;
      s = ty + 8'(len);
      src.send(ty);
      src.send(8'(len));
      for (k = 0; k < len; k++)
      begin
         src.send(pl[143-8*k -: 8]);
         s = s + pl[143-8*k -: 8];
      end
      src.send((~s + 8'h01) ^ flip);
      for (k = 0; k < 40 && pulses == seen; k++)
         @(negedge I_CLOCK);
      if (pulses == seen)
      begin
         error_cnt++;
         give_verdict();
      end
      seen = pulses;
   endtask : send_frame
   task automatic t_number(input logic [143:0] p);
      send_frame(8'h04, p, 18, 8'h00);
      `CHK(last_ok, 1'b1)
      `CHK(O_KIND, CNMP_KIND_NUMBER)
      `CHK(O_TYPE, 8'h04)
      `CHK(O_DATE, p[143:112])
      `CHK(O_TIME, p[111:80])
      `CHK(O_NUMBER, p[79:0])
      num_exp = p[79:0];
      $display("number frame done");
   endtask : t_number
   task automatic t_types();
      logic [7:0] ty [3];
      cnmp_kind_t kd [3];
      int i;
      ty = '{8'h06, 8'h08, 8'h2A};
      kd = '{CNMP_KIND_WAITING, CNMP_KIND_UNKNOWN, CNMP_KIND_UNKNOWN};
      for (i = 0; i < 3; i++)
      begin
         send_frame(ty[i], {"AB", 128'h0}, i, 8'h00);
         `CHK(last_ok, 1'b1)
         `CHK(O_KIND, kd[i])
         `CHK(O_NUMBER, num_exp)
      end
      $display("type frames done");
   endtask : t_types
   task automatic t_bad();
      send_frame(8'h04, "010100017775550000", 18, 8'h01);
      `CHK(last_ok, 1'b0)
      `CHK(O_NUMBER, num_exp)
      `CHK(O_TYPE, 8'h2A)
      $display("bad frame done");
   endtask : t_bad
   task automatic t_stall();
      I_HOLD = 1'b1;
      fork
         begin
            repeat (30) @(negedge I_CLOCK);
            I_HOLD = 1'b0;
         end
         t_number("123100009995551000");
      join
      $display("stall frame done");
   endtask : t_stall
   // Reset in mid-frame, then a clean frame from the type byte on
   task automatic t_reset();
      src.send(8'h04);
      src.send(8'h12);
      I_RST_N = 1'b0;
      repeat (8) @(negedge I_CLOCK);
      `CHK(O_FRAME_VALID, 1'b0)
      `CHK(O_FRAME_ERROR, 1'b0)
      `CHK(O_BYTE_READY, 1'b0)
      `CHK(O_KIND, CNMP_KIND_NONE)
      `CHK(O_TYPE, 8'h00)
      `CHK(O_DATE, 32'h0)
      `CHK(O_TIME, 32'h0)
      `CHK(O_NUMBER, 80'h0)
      I_RST_N = 1'b1;
      t_number("112207450005550199");
   endtask : t_reset
   initial
   begin
      repeat (8) @(negedge I_CLOCK);
      I_RST_N = 1'b1;
      t_number("030523590005551234");
      t_types();
      src.ring_gap(20);
      t_bad();
      t_stall();
      t_reset();
      give_verdict();
   end
endmodule : tb
